// ===== hdl/wrs_warm_reset_sequencer.sv
// Warm reset sequencer: drives the reset pin, latches start-up configuration,
// launches execution and holds the reset-out indicator until end of init.
// Assumes the reset pin is asynchronous and that the core reports access activity.
`timescale 1ns/100ps
module wrs_warm_reset_sequencer
    import wrs_pkg::*;
#(
    parameter int SEQ_CYCLES = SEQ_CYC
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    input  wire logic                 reset_input_pin_in,
    output logic                      reset_input_pin_out,
    output logic                      reset_input_pin_oe,
    input  wire logic [CFG_WIDTH-1:0] config_port_in,
    output logic                      config_port_pullup_en,
    input  wire logic                 access_busy,
    input  wire logic                 end_of_init_instruction,
    output logic                      hold_cancel,
    output logic                      core_reset,
    output logic                      fetch_start,
    output logic [23:0]               fetch_addr,
    output logic                      reset_out_indicator,
    output logic                      emulation_mode_bit,
    output logic                      mode_bit_a,
    output logic [2:0]                clock_config,
    output logic                      io_enable
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    logic sync1_reg;
    logic sync2_reg;
    logic pin_low;

    // Two flops before any logic reads the pin
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= reset_input_pin_in;
            sync2_reg <= sync1_reg;
        end
    end
    assign pin_low = ~sync2_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state
    wrs_state_t  state_reg;
    wrs_state_t  state_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        rst_ind_reg;
    logic        rst_ind_next;
    logic        fetch_reg;
    logic        fetch_next;
    logic [2:0]  clkcfg_reg;
    logic [2:0]  clkcfg_next;
    logic        emul_reg;
    logic        emul_next;
    logic        mode_a_reg;
    logic        mode_a_next;

    // Next-state logic
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        rst_ind_next = rst_ind_reg;
        fetch_next  = 1'b0;
        emul_next   = emul_reg;
        mode_a_next = mode_a_reg;
        clkcfg_next = clkcfg_reg;
        unique case (state_reg)
            WRS_RUN: begin
                if (pin_low) begin
                    state_next = WRS_DRAIN;
                end
            end
            WRS_DRAIN: begin
                // Wait for the running access to end
                if (!access_busy) begin
                    state_next = WRS_START;
                    cnt_next   = 16'h0000;
                end
            end
            WRS_START: begin
                // Short fixed wait inside the start window
                if (cnt_reg >= 16'(START_WAIT_CYC - 1)) begin
                    state_next = WRS_SEQ;
                    cnt_next   = 16'h0000;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end
            WRS_SEQ: begin
                rst_ind_next = 1'b1;
                if (cnt_reg >= 16'(SEQ_CYCLES - 1)) begin
                    state_next = WRS_WAIT_HIGH;
                end else begin
                    cnt_next = cnt_reg + 16'h0001;
                end
            end
            WRS_WAIT_HIGH: begin
                // Exit only once the pin reads high
                if (!pin_low) begin
                    state_next = WRS_INIT;
                    fetch_next = 1'b1;
                end
            end
            WRS_INIT: begin
                // Indicator released by end of init
                if (end_of_init_instruction) begin
                    rst_ind_next = 1'b0;
                    state_next  = WRS_RUN;
                end
            end
            default: begin
                state_next = WRS_RUN;
            end
        endcase
        // Configuration follows the port while reset is active
        if (core_reset) begin
            emul_next   = config_port_in[CFG_EMUL_BIT];
            mode_a_next = config_port_in[CFG_MODE_A_BIT];
            clkcfg_next = config_port_in[CFG_CLK_MSB:CFG_CLK_LSB];
        end
    end

    // State registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= WRS_RUN;
            cnt_reg    <= 16'h0000;
            rst_ind_reg <= 1'b0;
            fetch_reg  <= 1'b0;
            emul_reg   <= 1'b0;
            mode_a_reg <= 1'b0;
            clkcfg_reg <= 3'h0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            rst_ind_reg <= rst_ind_next;
            fetch_reg  <= fetch_next;
            emul_reg   <= emul_next;
            mode_a_reg <= mode_a_next;
            clkcfg_reg <= clkcfg_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hold_cancel           = (state_reg == WRS_DRAIN);
    assign core_reset            = (state_reg == WRS_SEQ) || (state_reg == WRS_WAIT_HIGH);
    assign reset_input_pin_out   = 1'b0;
    assign reset_input_pin_oe    = (state_reg == WRS_SEQ);
    assign config_port_pullup_en = core_reset;
    assign fetch_start           = fetch_reg;
    assign fetch_addr            = RESET_ADDR;
    assign reset_out_indicator   = rst_ind_reg;
    assign emulation_mode_bit    = emul_reg;
    assign mode_bit_a            = mode_a_reg;
    assign clock_config          = clkcfg_reg;
    assign io_enable             = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_pin_drive_seq: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == WRS_SEQ) |-> reset_input_pin_oe && !reset_input_pin_out)
        else $error("Reset pin not driven low during sequence");
    a_no_exit_low: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == WRS_WAIT_HIGH && pin_low) |=> (state_reg == WRS_WAIT_HIGH))
        else $error("Reset left while pin low");
    a_seq_length: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(state_reg == WRS_SEQ) |-> (state_reg == WRS_SEQ) [*8])
        else $error("Sequence ended too early");
    a_drain_busy: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == WRS_DRAIN && access_busy) |=> (state_reg == WRS_DRAIN))
        else $error("Reset entered during access");
    a_pullup_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == WRS_SEQ || state_reg == WRS_WAIT_HIGH) |-> config_port_pullup_en)
        else $error("Pull-ups off during reset");
    a_fetch_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == WRS_WAIT_HIGH && !pin_low) |=> fetch_start && fetch_addr == 24'h000000)
        else $error("Fetch not started at zero");
    a_reset_out_indicator_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == WRS_INIT && !end_of_init_instruction) |=> reset_out_indicator)
        else $error("Reset-out dropped before end of init");
    a_reset_out_indicator_rel: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == WRS_INIT && end_of_init_instruction) |=> !reset_out_indicator)
        else $error("Reset-out not released");
    a_io_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !io_enable)
        else $error("I/O enabled by reset logic");
    a_start_delay: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == WRS_RUN && pin_low && !access_busy) |-> ##[1:14] (state_reg == WRS_SEQ))
        else $error("Sequence start too late");
    a_cfg_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
        core_reset |=> emulation_mode_bit == $past(config_port_in[CFG_EMUL_BIT])
            && clock_config == $past(config_port_in[CFG_CLK_MSB:CFG_CLK_LSB]))
        else $error("Configuration bits not loaded");

    c_warm_reset: cover property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(state_reg == WRS_SEQ));
    c_wait_pin: cover property (@(posedge clk_sys) disable iff (!reset_n)
        (state_reg == WRS_WAIT_HIGH && pin_low) ##1 (state_reg == WRS_WAIT_HIGH));
    c_fetch: cover property (@(posedge clk_sys) disable iff (!reset_n) fetch_start);
    c_end_of_init_instruction: cover property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(reset_out_indicator));

endmodule

// ===== common/wrs_pkg.sv
// Package for the warm reset sequencer: timing counts and configuration layout.
// Assumes a single CPU clock of 200 MHz; one half-period unit equals one clock cycle.
package wrs_pkg;
    // Clock period in ns and the half-period time unit in ns
    localparam int CLK_PERIOD_NS          = 5;
    localparam int HALF_PERIOD_NS         = 5;
    // Start delay window in half-period units
    localparam int START_MIN_UNITS        = 4;
    localparam int START_MAX_UNITS        = 16;
    // Internal reset sequence length in half-period units
    localparam int SEQ_UNITS              = 1024;
    // Derived cycle counts (least rounds up, longest rounds down)
    localparam int START_MIN_CYC =
        (START_MIN_UNITS * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int START_MAX_CYC = (START_MAX_UNITS * HALF_PERIOD_NS) / CLK_PERIOD_NS;
    localparam int SEQ_CYC       =
        (SEQ_UNITS * HALF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Start delay chosen inside the window: sync (2), one cycle each in RUN and DRAIN, plus this wait
    localparam int START_WAIT_CYC         = START_MIN_CYC;
    // Configuration port layout
    localparam int CFG_WIDTH              = 16;
    localparam int CFG_EMUL_BIT           = 0;
    localparam int CFG_MODE_A_BIT         = 1;
    localparam int CFG_CLK_LSB            = 13;
    localparam int CFG_CLK_MSB            = 15;
    // Reset address
    localparam logic [23:0] RESET_ADDR    = 24'h00_0000;
    // Sequencer states
    typedef enum logic [2:0] {
        WRS_RUN,
        WRS_DRAIN,
        WRS_START,
        WRS_SEQ,
        WRS_WAIT_HIGH,
        WRS_INIT
    } wrs_state_t;
endpackage

// ===== tb/wrs_reset_source.sv
// Far side model: reset source on the pulled-up reset pin and the config port straps.
// Assumes the device drives the pin through out/oe and reports pull-up enable.
`timescale 1ns/100ps
module wrs_reset_source (
    clk_sys,
    pull_low,
    dev_out,
    dev_oe,
    pullup_en,
    pulldown_mask,
    pin_level,
    config_port
);
    input  wire logic        clk_sys;
    input  wire logic        pull_low;
    input  wire logic        dev_out;
    input  wire logic        dev_oe;
    input  wire logic        pullup_en;
    input  wire logic [15:0] pulldown_mask;
    output logic             pin_level;
    output logic [15:0]      config_port;
    logic [15:0]             float_reg = 16'h5a5a;
    ///////////////////////////////////////////////////////////////////////////
    // Wired-AND pin with pull-up: low if either party pulls it down
    assign pin_level = (pull_low || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
    // Open straps float without pull-ups, so they show a changing pattern
    always @(posedge clk_sys) begin
        float_reg <= ~float_reg;
    end
    // Open strap reads one with pull-ups on, strapped-down pin reads zero
    assign config_port = pullup_en ? ~pulldown_mask : (float_reg & ~pulldown_mask);
endmodule

// ===== tb/wrs_warm_reset_sequencer_tb.sv
// Testbench for the warm reset sequencer with a shortened internal sequence.
// Assumes the reset source model in the tb folder.
`timescale 1ns/100ps
module wrs_warm_reset_sequencer_tb;
    import wrs_pkg::*;
    localparam int SEQ_N = 16;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        pull_low = 1'b0;
    logic        access_busy = 1'b0;
    logic        eoi = 1'b0;
    logic [15:0] pulldown_mask = 16'h0000;
    logic        pin_level, pin_out, pin_oe, pullup_en, hold_cancel, core_reset;
    logic        fetch_start, reset_out, emul, mode_a, io_en;
    logic [23:0] fetch_addr;
    logic [2:0]  clk_cfg;
    logic [15:0] cfg;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cyc = 0;
    int          n;
    ///////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    wrs_reset_source i_src (.clk_sys(clk_sys), .pull_low(pull_low), .dev_out(pin_out),
        .dev_oe(pin_oe), .pullup_en(pullup_en), .pulldown_mask(pulldown_mask),
        .pin_level(pin_level), .config_port(cfg));
    wrs_warm_reset_sequencer #(.SEQ_CYCLES(SEQ_N)) i_dut (.clk_sys(clk_sys),
        .reset_n(reset_n), .reset_input_pin_in(pin_level), .reset_input_pin_out(pin_out),
        .reset_input_pin_oe(pin_oe), .config_port_in(cfg), .config_port_pullup_en(pullup_en),
        .access_busy(access_busy), .end_of_init_instruction(eoi), .hold_cancel(hold_cancel),
        .core_reset(core_reset), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
        .reset_out_indicator(reset_out), .emulation_mode_bit(emul), .mode_bit_a(mode_a),
        .clock_config(clk_cfg), .io_enable(io_en));
    ///////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string msg);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic results();
        $display("checks %0d, errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Fetch starts at zero, indicator holds until end of init
    task automatic leave_reset();
        n = 0;
        while (fetch_start !== 1'b1 && n < 2 * SEQ_N + 20) begin
            tick();
            n++;
        end
        check({fetch_start, core_reset}, 2'b10, "fetch start missing");
        check(fetch_addr, RESET_ADDR, "fetch address");
        repeat (5) begin
            tick();
            check({reset_out, io_en}, 2'b10, "indicator dropped early");
        end
        @(posedge clk_sys) eoi <= 1'b1;
        @(posedge clk_sys) eoi <= 1'b0;
        #1 check(reset_out, 1'b0, "indicator not released");
    endtask
    ///////////////////////////////////////////////////////////////////////////
    // Short pin pulse while an access is running; straps change mid-reset
    task automatic warm_busy();
        @(posedge clk_sys);
        access_busy <= 1'b1;
        pulldown_mask <= 16'h2001;
        pull_low <= 1'b1;
        n = 0;
        while (hold_cancel !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        check(hold_cancel, 1'b1, "holds not cancelled");
        repeat (4) begin
            tick();
            check(pin_oe, 1'b0, "pin driven during access");
        end
        @(posedge clk_sys);
        access_busy <= 1'b0;
        pull_low <= 1'b0;
        n = 0;
        while (pin_oe !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        check(24'(n <= START_MAX_CYC), 1, "sequence started late");
        tick();
        check(pin_level, 1'b0, "pin not held low");
        check({core_reset, pullup_en, io_en}, 3'b110, "reset outputs");
        check({emul, mode_a, clk_cfg}, 5'b01110, "first straps");
        @(posedge clk_sys) pulldown_mask <= 16'h0002;
        repeat (3) tick();
        check({emul, mode_a, clk_cfg}, 5'b10111, "straps not reloaded");
        leave_reset();
    endtask
    // Source keeps the pin low past the sequence
    task automatic hold_low();
        @(posedge clk_sys) pull_low <= 1'b1;
        n = 0;
        while (pin_oe !== 1'b1 && n < 40) begin
            tick();
            n++;
        end
        n = 0;
        while (pin_oe === 1'b1 && n < SEQ_N + 8) begin
            tick();
            n++;
        end
        check(24'(n), 24'(SEQ_N), "drive length");
        repeat (8) begin
            tick();
            check({core_reset, fetch_start}, 2'b10, "left reset with pin low");
        end
        @(posedge clk_sys) pull_low <= 1'b0;
        leave_reset();
    endtask
    ///////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (2) tick();
        warm_busy();
        hold_low();
        results();
    end
endmodule
